/* File: core/acr_codec_regs.sv */
// Codec control register bank with APB slave and side-tone mixer.
// Assumes converter samples and offset word arrive on i_ref_clk.
// Functional notes
// - side-tone mixed only when enable bit set
// - 6 dB gain steps, reset code 011
// - clock-off bit stops converter clocks
// - digital part off on clock-off or all-powerdown
// - data read returns input sample
// - data write loads output sample register
// - input dither on unless disable bit set
// - output dither on unless disable bit set
// - output converter powerdown, resets to one
// - input converter powerdown, resets to one
// - offset register reads error word, read-only
// - reference amplifier powerdown, resets to one
// - shared bias powerdown, resets to one
// - buffer resistor select, resets to one
// - voice input amplifier powerdown bit
// - negative speaker amplifier powerdown bit
// - positive speaker amplifier powerdown bit
`timescale 1ns/1ps
`default_nettype none
module acr_codec_regs
  import acr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [15:0] i_in_sample,
  input wire logic [15:0] i_offset_error,
  output logic [15:0] o_out_sample,
  output logic o_conv_clk_en,
  output logic o_digital_en,
  output logic o_in_dither_en,
  output logic o_out_dither_en,
  output logic o_in_conv_pd,
  output logic o_out_conv_pd,
  output logic o_int_ref_pd,
  output logic o_ref_amp_pd,
  output logic o_amp_bias_powerdown,
  output logic o_bandgap_pd,
  output logic o_buf_res_sel,
  output logic o_voice_pd,
  output logic [3:0] o_voice_gain,
  output logic o_spk_pos_pd,
  output logic o_spk_neg_pd,
  output logic [12:0] o_test_ctrl
);
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic amp_bias_powerdown_ff, bg_pd_ff, buf_sel_ff, ref_pd_ff;
  logic st_on_ff, coff_ff, internal_reference_powerdown_ff, in_dith_off_ff, out_dith_off_ff;
  logic out_pd_ff, in_pd_ff, voice_pd_ff, spk_pos_pd_ff, spk_neg_pd_ff;
  logic [2:0] st_gain_ff;
  logic [3:0] voice_gain_ff;
  logic [15:0] out_word_ff;
  logic [12:0] test_ff;
  logic [31:0] prdata_ff;
  logic [15:0] dac_ff;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic setup_ph = i_psel && !i_penable;
  wire logic acc_ph = i_psel && i_penable;
  wire logic wr_en = acc_ph && i_pwrite;
  wire logic hit_voice = (i_paddr == ACR_A_VOICE);
  wire logic hit_spk = (i_paddr == ACR_A_SPEAKER);
  wire logic hit_ref = (i_paddr == ACR_A_REF);
  wire logic hit_data = (i_paddr == ACR_A_DATA);
  wire logic hit_adda = (i_paddr == ACR_A_ADDA);
  wire logic hit_off = (i_paddr == ACR_A_OFFSET);
  wire logic hit_test = (i_paddr == ACR_A_TEST);
  wire logic mapped = hit_voice || hit_spk || hit_ref || hit_data || hit_adda
                      || hit_off || hit_test;

  // Reserved positions are simply not wired into the read words
  wire logic [15:0] rd_ref = {8'h00, amp_bias_powerdown_ff, bg_pd_ff, 1'b0, buf_sel_ff, 3'h0,
                              ref_pd_ff};
  wire logic [15:0] rd_adda = {st_on_ff, st_gain_ff, 1'b0, coff_ff, 3'h0, internal_reference_powerdown_ff,
                               2'h0, in_dith_off_ff, out_dith_off_ff, out_pd_ff,
                               in_pd_ff};
  wire logic [15:0] rd_voice = {8'h00, voice_gain_ff, 1'b0, voice_pd_ff, 2'h0};
  wire logic [15:0] rd_spk = {10'h000, spk_neg_pd_ff, 2'h0, spk_pos_pd_ff, 2'h0};
  wire logic [15:0] rd_test = {3'h0, test_ff};
  logic [15:0] rd_mux;
  always_comb begin
    if (hit_ref) begin
      rd_mux = rd_ref;
    end else if (hit_data) begin
      rd_mux = i_in_sample;
    end else if (hit_adda) begin
      rd_mux = rd_adda;
    end else if (hit_off) begin
      rd_mux = i_offset_error;
    end else if (hit_voice) begin
      rd_mux = rd_voice;
    end else if (hit_spk) begin
      rd_mux = rd_spk;
    end else if (hit_test) begin
      rd_mux = rd_test;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // APB answer: zero wait states, read word caught in setup
  // ---------------------------------------------------------------
  assign o_pready = 1'b1;
  assign o_pslverr = acc_ph && !mapped;
  assign o_prdata = prdata_ff;
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_ph && !i_pwrite) begin
      prdata_ff <= {16'h0000, rd_mux};
    end
  end

  // ---------------------------------------------------------------
  // Writable registers, effective the cycle after the access
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      amp_bias_powerdown_ff <= ACR_RST_PD;
      bg_pd_ff <= ACR_RST_BG_PD;
      buf_sel_ff <= ACR_RST_BUF_SEL;
      ref_pd_ff <= ACR_RST_PD;
    end else if (wr_en && hit_ref) begin
      amp_bias_powerdown_ff <= i_pwdata[ACR_REF_AMP_BIAS_POWERDOWN];
      bg_pd_ff <= i_pwdata[ACR_REF_BG_PD];
      buf_sel_ff <= i_pwdata[ACR_REF_BUF_SEL];
      ref_pd_ff <= i_pwdata[ACR_REF_AMP_PD];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st_on_ff <= ACR_RST_OFF;
      st_gain_ff <= ACR_RST_ST_GAIN;
      coff_ff <= ACR_RST_OFF;
      internal_reference_powerdown_ff <= ACR_RST_PD;
      in_dith_off_ff <= ACR_RST_OFF;
      out_dith_off_ff <= ACR_RST_OFF;
      out_pd_ff <= ACR_RST_PD;
      in_pd_ff <= ACR_RST_PD;
    end else if (wr_en && hit_adda) begin
      st_on_ff <= i_pwdata[ACR_ADDA_ST_ON];
      st_gain_ff <= i_pwdata[ACR_ADDA_ST_LSB +: 3];
      coff_ff <= i_pwdata[ACR_CONVERTER_CLOCK_OFF];
      internal_reference_powerdown_ff <= i_pwdata[ACR_ADDA_INTERNAL_REFERENCE_POWERDOWN];
      in_dith_off_ff <= i_pwdata[ACR_ADDA_IN_DITH];
      out_dith_off_ff <= i_pwdata[ACR_ADDA_OUT_DITH];
      out_pd_ff <= i_pwdata[ACR_ADDA_OUT_PD];
      in_pd_ff <= i_pwdata[ACR_ADDA_IN_PD];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      voice_pd_ff <= ACR_RST_PD;
      voice_gain_ff <= ACR_RST_VOICE_GAIN;
      spk_pos_pd_ff <= ACR_RST_PD;
      spk_neg_pd_ff <= ACR_RST_PD;
    end else if (wr_en && hit_voice) begin
      voice_pd_ff <= i_pwdata[ACR_VOICE_PD];
      voice_gain_ff <= i_pwdata[ACR_VOICE_GAIN_LSB +: 4];
    end else if (wr_en && hit_spk) begin
      spk_pos_pd_ff <= i_pwdata[ACR_SPK_POS_PD];
      spk_neg_pd_ff <= i_pwdata[ACR_SPK_NEG_PD];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      out_word_ff <= ACR_RST_SAMPLE;
      test_ff <= ACR_RST_TEST;
    end else if (wr_en && hit_data) begin
      out_word_ff <= i_pwdata[15:0];
    end else if (wr_en && hit_test) begin
      test_ff <= i_pwdata[ACR_TEST_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Power, clock and dither controls
  // ---------------------------------------------------------------
  wire logic all_pd = in_pd_ff && out_pd_ff && voice_pd_ff && spk_pos_pd_ff
                      && spk_neg_pd_ff;
  wire logic dig_on = !coff_ff && !all_pd;
  assign o_digital_en = dig_on;
  assign o_conv_clk_en = !coff_ff;
  assign o_in_dither_en = !in_dith_off_ff;
  assign o_out_dither_en = !out_dith_off_ff;
  assign o_in_conv_pd = in_pd_ff;
  assign o_out_conv_pd = out_pd_ff;
  assign o_int_ref_pd = internal_reference_powerdown_ff;
  assign o_ref_amp_pd = ref_pd_ff;
  assign o_amp_bias_powerdown = amp_bias_powerdown_ff;
  assign o_bandgap_pd = bg_pd_ff;
  assign o_buf_res_sel = buf_sel_ff;
  assign o_voice_pd = voice_pd_ff;
  assign o_voice_gain = voice_gain_ff;
  assign o_spk_pos_pd = spk_pos_pd_ff;
  assign o_spk_neg_pd = spk_neg_pd_ff;
  assign o_test_ctrl = test_ff;

  // ---------------------------------------------------------------
  // Side-tone mixer with saturation
  // ---------------------------------------------------------------
  // One arithmetic shift per 6 dB step
  wire logic signed [15:0] st_att = $signed(i_in_sample) >>> st_gain_ff;
  wire logic signed [15:0] st_add = st_on_ff ? st_att : 16'sh0000;
  wire logic signed [16:0] mix_sum = {out_word_ff[15], out_word_ff}
                                     + {st_add[15], st_add};
  wire logic [15:0] mix_sat = (mix_sum[16] != mix_sum[15])
                              ? {mix_sum[16], {15{~mix_sum[16]}}} : mix_sum[15:0];
  assign o_out_sample = dac_ff;
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      dac_ff <= ACR_RST_SAMPLE;
    end else if (dig_on) begin
      dac_ff <= mix_sat;
    end else begin
      dac_ff <= ACR_RST_SAMPLE;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_setup_rd(logic h);
    i_psel && !i_penable && !i_pwrite && h;
  endsequence
  sequence s_acc_wr(logic h);
    i_psel && i_penable && i_pwrite && h;
  endsequence

  chk_sidetone_bypass: assert property (
    dig_on && !st_on_ff |=> o_out_sample == $past(out_word_ff))
    else $error("side-tone not bypassed");
  chk_sidetone_full_gain: assert property (
    dig_on && st_on_ff && st_gain_ff == 3'h0 && out_word_ff == 16'h0000
    |=> o_out_sample == $past(i_in_sample))
    else $error("side-tone 0 dB path wrong");
  chk_clock_off_write: assert property (
    s_acc_wr(hit_adda) ##0 i_pwdata[ACR_CONVERTER_CLOCK_OFF] |=> !o_conv_clk_en && !o_digital_en)
    else $error("clock-off write not effective");
  chk_digital_off_zero: assert property (
    all_pd |=> o_out_sample == 16'h0000)
    else $error("digital part not gated");
  chk_sample_read: assert property (
    s_setup_rd(hit_data) |=> o_prdata == {16'h0000, $past(i_in_sample)})
    else $error("sample read mismatch");
  chk_sample_write: assert property (
    s_acc_wr(hit_data) |=> out_word_ff == $past(i_pwdata[15:0]))
    else $error("output sample not loaded");
  chk_dither_write: assert property (
    s_acc_wr(hit_adda) |=> o_in_dither_en == !$past(i_pwdata[ACR_ADDA_IN_DITH])
                           && o_out_dither_en == !$past(i_pwdata[ACR_ADDA_OUT_DITH]))
    else $error("dither control wrong");
  chk_offset_read: assert property (
    s_setup_rd(hit_off) |=> o_prdata[15:0] == $past(i_offset_error))
    else $error("offset read mismatch");
  chk_reserved_zero: assert property (
    s_setup_rd(hit_ref || hit_adda) |=> o_prdata[31:16] == 16'h0000
                                        && (o_prdata & 32'h0000_0800) == 32'h0)
    else $error("reserved bits not zero");
  chk_unmapped_err: assert property (
    i_psel && i_penable && !mapped |-> o_pslverr && o_pready)
    else $error("unmapped access not flagged");

  // ---------------------------------------------------------------
  // Register write effects
  // ---------------------------------------------------------------
  chk_ref_write: assert property (
    s_acc_wr(hit_ref) |=> o_ref_amp_pd == $past(i_pwdata[ACR_REF_AMP_PD])
      && o_amp_bias_powerdown == $past(i_pwdata[ACR_REF_AMP_BIAS_POWERDOWN])
      && o_buf_res_sel == $past(i_pwdata[ACR_REF_BUF_SEL]))
    else $error("reference control write not effective");
  chk_conv_pd_write: assert property (
    s_acc_wr(hit_adda) |=> o_out_conv_pd == $past(i_pwdata[ACR_ADDA_OUT_PD])
      && o_in_conv_pd == $past(i_pwdata[ACR_ADDA_IN_PD]))
    else $error("converter powerdown write not effective");
  chk_gain_write: assert property (
    s_acc_wr(hit_adda) |=> st_gain_ff == $past(i_pwdata[ACR_ADDA_ST_LSB +: 3]))
    else $error("side-tone gain write not effective");
  chk_voice_pd_write: assert property (
    s_acc_wr(hit_voice) |=> o_voice_pd == $past(i_pwdata[ACR_VOICE_PD]))
    else $error("voice powerdown write not effective");
  chk_spk_pd_write: assert property (
    s_acc_wr(hit_spk) |=> o_spk_pos_pd == $past(i_pwdata[ACR_SPK_POS_PD])
      && o_spk_neg_pd == $past(i_pwdata[ACR_SPK_NEG_PD]))
    else $error("speaker powerdown write not effective");
  // Reset must not disable its own check
  chk_reset_values: assert property (
    @(posedge i_ref_clk) disable iff (1'b0)
    !i_reset_n |=> o_in_conv_pd && o_out_conv_pd
      && o_ref_amp_pd && o_amp_bias_powerdown && o_buf_res_sel
      && st_gain_ff == ACR_RST_ST_GAIN)
    else $error("reset values wrong");
endmodule
`default_nettype wire

/* File: core/acr_pkg.sv */
// Constants for the codec control register bank.
// Assumes an APB master with 32-bit data and word-aligned register slots.
package acr_pkg;
  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam int ACR_ADDR_W = 16;
  localparam logic [15:0] ACR_IDX_VOICE = 16'h1280;
  localparam logic [15:0] ACR_IDX_SPEAKER = 16'h1282;
  localparam logic [15:0] ACR_IDX_REF = 16'h1284;
  localparam logic [15:0] ACR_IDX_DATA = 16'h1286;
  localparam logic [15:0] ACR_IDX_ADDA = 16'h1288;
  localparam logic [15:0] ACR_IDX_OFFSET = 16'h128A;
  localparam logic [15:0] ACR_IDX_TEST = 16'h128C;
  localparam logic [15:0] ACR_A_VOICE = {ACR_IDX_VOICE[13:0], 2'b00};
  localparam logic [15:0] ACR_A_SPEAKER = {ACR_IDX_SPEAKER[13:0], 2'b00};
  localparam logic [15:0] ACR_A_REF = {ACR_IDX_REF[13:0], 2'b00};
  localparam logic [15:0] ACR_A_DATA = {ACR_IDX_DATA[13:0], 2'b00};
  localparam logic [15:0] ACR_A_ADDA = {ACR_IDX_ADDA[13:0], 2'b00};
  localparam logic [15:0] ACR_A_OFFSET = {ACR_IDX_OFFSET[13:0], 2'b00};
  localparam logic [15:0] ACR_A_TEST = {ACR_IDX_TEST[13:0], 2'b00};
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ACR_REF_AMP_BIAS_POWERDOWN = 7;
  localparam int ACR_REF_BG_PD = 6;
  localparam int ACR_REF_BUF_SEL = 4;
  localparam int ACR_REF_AMP_PD = 0;
  localparam int ACR_ADDA_ST_ON = 15;
  localparam int ACR_ADDA_ST_LSB = 12;
  localparam int ACR_CONVERTER_CLOCK_OFF = 10;
  localparam int ACR_ADDA_INTERNAL_REFERENCE_POWERDOWN = 6;
  localparam int ACR_ADDA_IN_DITH = 3;
  localparam int ACR_ADDA_OUT_DITH = 2;
  localparam int ACR_ADDA_OUT_PD = 1;
  localparam int ACR_ADDA_IN_PD = 0;
  localparam int ACR_VOICE_GAIN_LSB = 4;
  localparam int ACR_VOICE_PD = 2;
  localparam int ACR_SPK_NEG_PD = 5;
  localparam int ACR_SPK_POS_PD = 2;
  localparam int ACR_TEST_W = 13;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] ACR_RST_ST_GAIN = 3'h3;
  localparam logic ACR_RST_PD = 1'b1;
  localparam logic ACR_RST_BG_PD = 1'b0;
  localparam logic ACR_RST_BUF_SEL = 1'b1;
  localparam logic ACR_RST_OFF = 1'b0;
  localparam logic [3:0] ACR_RST_VOICE_GAIN = 4'h0;
  localparam logic [15:0] ACR_RST_SAMPLE = 16'h0000;
  localparam logic [12:0] ACR_RST_TEST = 13'h0000;
endpackage

/* File: tb/acr_analog_model.sv */
// Behavioural analog side: input converter word and offset error source.
// Assumes the bench supplies the level that the input converter digitises.
`timescale 1ns/1ps
`default_nettype none
module acr_analog_model (
  input wire logic i_ref_clk,
  input wire logic i_in_conv_pd,
  input wire logic i_conv_clk_en,
  input wire logic [3:0] i_voice_gain,
  input wire logic [15:0] i_level,
  output logic [15:0] o_in_sample,
  output logic [15:0] o_offset_error
);
  // ---------------------------------------------------------------
  // Converter word
  // ---------------------------------------------------------------
  initial o_in_sample = 16'h0000;
  // Word moves only while clocked and powered
  always @(posedge i_ref_clk) begin
    if (i_conv_clk_en && !i_in_conv_pd) begin
      o_in_sample <= i_level;
    end
  end
  // ---------------------------------------------------------------
  // Offset error, distinct for each gain setting
  // ---------------------------------------------------------------
  assign o_offset_error = 16'hFFF0 + {12'h000, i_voice_gain};
endmodule
`default_nettype wire

/* File: tb/acr_codec_regs_tb.sv */
// Self-checking bench for the codec register bank over APB.
// Assumes zero-wait APB slave and the analog model on the far side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); \
  end \
end
module acr_codec_regs_tb import acr_pkg::*;;
  logic ref_clk = 1'b0;
  logic reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] paddr, in_sample, offset_error, out_sample, level;
  logic [31:0] pwdata, prdata, rd;
  logic conv_clk_en, digital_en, in_dith, out_dith, in_pd, out_pd, int_ref_pd;
  logic ref_amp_pd, amp_bias_powerdown, bg_pd, buf_sel, voice_pd, spk_p, spk_n;
  logic [3:0] voice_gain;
  logic [12:0] test_ctrl;
  int err_total = 0;
  int samples_checked = 0;
  int g;
  always #12.5 ref_clk = ~ref_clk;
  acr_codec_regs acr_codec_regs_inst (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_in_sample(in_sample),
    .i_offset_error(offset_error), .o_out_sample(out_sample), .o_conv_clk_en(conv_clk_en),
    .o_digital_en(digital_en), .o_in_dither_en(in_dith), .o_out_dither_en(out_dith),
    .o_in_conv_pd(in_pd), .o_out_conv_pd(out_pd), .o_int_ref_pd(int_ref_pd),
    .o_ref_amp_pd(ref_amp_pd), .o_amp_bias_powerdown(amp_bias_powerdown), .o_bandgap_pd(bg_pd),
    .o_buf_res_sel(buf_sel), .o_voice_pd(voice_pd), .o_voice_gain(voice_gain),
    .o_spk_pos_pd(spk_p), .o_spk_neg_pd(spk_n), .o_test_ctrl(test_ctrl));
  acr_analog_model acr_analog_model_inst (
    .i_ref_clk(ref_clk), .i_in_conv_pd(in_pd), .i_conv_clk_en(conv_clk_en),
    .i_voice_gain(voice_gain), .i_level(level), .o_in_sample(in_sample),
    .o_offset_error(offset_error));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      finish_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, rd, err);
    `CHK(nm, exp, rd)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    level = 16'h1234;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_chk("ref", ACR_A_REF, 32'h0000_0091);
    rd_chk("adda", ACR_A_ADDA, 32'h0000_3043);
    rd_chk("offset", ACR_A_OFFSET, 32'h0000_FFF0);
    `CHK("dig_en", 1'b0, digital_en)
    `CHK("dither", 3'b111, {in_dith, out_dith, conv_clk_en})
    $display("test 1 done");
    wr(ACR_A_REF, 32'hFFFF_FFFF);
    rd_chk("ref ones", ACR_A_REF, 32'h0000_00D1);
    `CHK("ref pins", 4'hF, {amp_bias_powerdown, bg_pd, buf_sel, ref_amp_pd})
    wr(ACR_A_REF, 32'h0000_0000);
    tick(2);
    `CHK("ref pins", 4'h0, {amp_bias_powerdown, bg_pd, buf_sel, ref_amp_pd})
    $display("test 2 done");
    wr(ACR_A_ADDA, 32'h0000_FFFF);
    rd_chk("adda ones", ACR_A_ADDA, 32'h0000_F44F);
    `CHK("clk_en", 1'b0, conv_clk_en)
    `CHK("dig_en", 1'b0, digital_en)
    `CHK("dither", 2'b00, {in_dith, out_dith})
    `CHK("pd", 3'b111, {in_pd, out_pd, int_ref_pd})
    wr(ACR_A_ADDA, 32'h0000_0003);
    tick(1);
    `CHK("int ref", 1'b0, int_ref_pd)
    wr(ACR_A_ADDA, 32'h0000_0000);
    tick(3);
    `CHK("pd", 3'b000, {in_pd, out_pd, int_ref_pd})
    `CHK("dig_en", 1'b1, digital_en)
    rd_chk("data in", ACR_A_DATA, 32'h0000_1234);
    $display("test 3 done");
    wr(ACR_A_DATA, 32'hABCD_0100);
    tick(3);
    `CHK("out", 16'h0100, out_sample)
    rd_chk("data in", ACR_A_DATA, 32'h0000_1234);
    for (g = 0; g < 8; g++) begin
      wr(ACR_A_ADDA, 32'h0000_8000 | (g << 12));
      tick(3);
      `CHK("sidetone", 16'h0100 + (16'h1234 >> g), out_sample)
    end
    rd_chk("adda", ACR_A_ADDA, 32'h0000_F000);
    wr(ACR_A_ADDA, 32'h0000_8000);
    wr(ACR_A_DATA, 32'h0000_0000);
    level <= 16'h2468;
    tick(3);
    `CHK("sidetone 0dB", 16'h2468, out_sample)
    rd_chk("data new", ACR_A_DATA, 32'h0000_2468);
    $display("test 4 done");
    wr(ACR_A_ADDA, 32'h0000_0400);
    tick(3);
    `CHK("clk_en", 1'b0, conv_clk_en)
    `CHK("off", 17'h0_0000, {digital_en, out_sample})
    wr(ACR_A_ADDA, 32'h0000_0003);
    tick(2);
    `CHK("dig_en", 1'b0, digital_en)
    wr(ACR_A_VOICE, 32'h0000_0050);
    tick(2);
    `CHK("voice", 6'h15, {voice_pd, digital_en, voice_gain})
    rd_chk("offset", ACR_A_OFFSET, 32'h0000_FFF5);
    wr(ACR_A_OFFSET, 32'h0000_1111);
    rd_chk("offset ro", ACR_A_OFFSET, 32'h0000_FFF5);
    wr(ACR_A_SPEAKER, 32'h0000_0000);
    tick(2);
    `CHK("spk", 2'b00, {spk_p, spk_n})
    wr(ACR_A_SPEAKER, 32'h0000_0024);
    tick(2);
    `CHK("spk", 2'b11, {spk_p, spk_n})
    $display("test 5 done");
    xfer(1'b0, 16'h0004, 32'h0000_0000, rd, err);
    `CHK("unmapped rd", 33'h1_0000_0000, {err, rd})
    xfer(1'b1, 16'h0004, 32'hFFFF_FFFF, rd, err);
    `CHK("unmapped wr", 1'b1, err)
    wr(ACR_A_TEST, 32'hFFFF_FFFF);
    rd_chk("test", ACR_A_TEST, 32'h0000_1FFF);
    `CHK("test pins", 13'h1FFF, test_ctrl)
    $display("test 6 done");
    finish_test();
  end
endmodule
`default_nettype wire
